// [common/clbe_defines.svh]
// Register offsets, flag positions and reset values of the link byte block
`ifndef CLBE_DEFINES_SVH
`define CLBE_DEFINES_SVH

`define CLBE_OFS_CTRL 12'h000
`define CLBE_OFS_CFG 12'h004
`define CLBE_OFS_TXBYTE 12'h008
`define CLBE_OFS_RXBYTE 12'h00c
`define CLBE_OFS_STATUS 12'h010
`define CLBE_OFS_ENABLE 12'h014

`define CLBE_NFLAGS 13
`define CLBE_RX_BYTE_READY_FLAG 0
`define CLBE_RX_DONE_FLAG 1
`define CLBE_RX_OVERRUN_FLAG 2
`define CLBE_BRE 3
`define CLBE_SHORT_PERIOD_ERROR_FLAG 4
`define CLBE_LONG_PERIOD_ERROR_FLAG 5
`define CLBE_RXACK 6
`define CLBE_ARBL 7
`define CLBE_TX_BYTE_REQUEST_FLAG 8
`define CLBE_TX_DONE_FLAG 9
`define CLBE_TX_UNDERRUN_FLAG 10
`define CLBE_TX_LINE_ERROR_FLAG 11
`define CLBE_TXACK 12

`define CLBE_CTRL_EN 0
`define CLBE_CTRL_SOM 1
`define CLBE_CTRL_EOM 2

`define CLBE_CFG_BRESTOP 4
`define CLBE_CFG_RISING_ERROR_ERRBIT_EN 5
`define CLBE_CFG_LONG_PERIOD_ERRBIT_EN 6
`define CLBE_CFG_LISTEN 31

`define CLBE_RESET_WORD 32'h0000_0000
`endif

// [common/clbe_pkg.sv]
// Types shared by the link byte block
package clbe_pkg;
    typedef logic [12:0] clbe_flags_t;

    // Events from the bit engine, one-cycle pulses
    typedef struct packed {
        logic txAckMiss;
        logic txLineErr;
        logic txByteNeed;
        logic txLastDone;
        logic txFourthBit;
        logic arbLost;
        logic rxAckMiss;
        logic longPeriod;
        logic shortPeriod;
        logic risingErr;
        logic rxByteStore;
        logic rxLast;
        logic rxBroadcast;
        logic rxForeign;
    } clbe_evt_t;

    // Control toward the bit engine
    typedef struct packed {
        logic enable;
        logic startMsg;
        logic endMsg;
        logic listen;
        logic abortTx;
        logic stopRx;
        logic errorBit;
        logic nack;
    } clbe_ctl_t;

    typedef enum logic [2:0] {
        CLBE_IDLE = 3'b001,
        CLBE_SEND = 3'b010,
        CLBE_RECV = 3'b100
    } clbe_state_t;
endpackage

// [design/clbe_core.sv]
// Byte buffers, event flags and enables of the single-wire link controller
//
// Implementation choice: the APB register port.
`include "clbe_defines.svh"

module clbe_core
    import clbe_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bit engine side
    input wire clbe_evt_t evt,
    input wire logic [7:0] rxByte,
    output clbe_ctl_t ctl,
    output logic [7:0] txByte,
    output logic txByteValid,
    output clbe_state_t linkState,
    // Interrupt
    output logic irq
);
    logic [2:0] ctrl_r;
    logic [31:0] cfg_r;
    logic [7:0] txByte_r;
    logic txValid_r;
    logic [7:0] rxByte_r;
    clbe_flags_t flags_r;
    clbe_flags_t flags_nxt;
    clbe_flags_t ien_r;
    clbe_state_t state_r;
    clbe_ctl_t ctl_r;
    logic wrEn;
    logic rdEn;
    logic hit;
    logic txAbort;
    logic rxStop;
    logic overrun;
    logic bcast;

    function automatic logic isReg(input logic [11:0] a,
                                   input logic [11:0] ofs);
        return a == ofs;
    endfunction

    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    assign hit = isReg(paddr, `CLBE_OFS_CTRL) || isReg(paddr, `CLBE_OFS_CFG)
        || isReg(paddr, `CLBE_OFS_TXBYTE) || isReg(paddr, `CLBE_OFS_RXBYTE)
        || isReg(paddr, `CLBE_OFS_STATUS) || isReg(paddr, `CLBE_OFS_ENABLE);
    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    assign bcast = evt.rxBroadcast;
    assign overrun = evt.rxByteStore && flags_r[`CLBE_RX_BYTE_READY_FLAG];
    assign txAbort = evt.txAckMiss || evt.txLineErr
        || (evt.txByteNeed && !txValid_r);
    assign rxStop = evt.longPeriod || overrun
        || (evt.risingErr && cfg_r[`CLBE_CFG_BRESTOP])
        || (evt.rxAckMiss && (bcast || evt.rxForeign));

    // Control register; software may only set start/end while enabled
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ctrl_r <= 3'h0;
        else if (wrEn && isReg(paddr, `CLBE_OFS_CTRL) && pstrb[0]
                 && !pwdata[`CLBE_CTRL_EN])
            ctrl_r <= 3'h0;
        else if (!ctrl_r[`CLBE_CTRL_EN])
        begin
            if (wrEn && isReg(paddr, `CLBE_OFS_CTRL) && pstrb[0])
                ctrl_r[`CLBE_CTRL_EN] <= pwdata[`CLBE_CTRL_EN];
        end
        else
        begin
            if (wrEn && isReg(paddr, `CLBE_OFS_CTRL) && pstrb[0])
            begin
                if (pwdata[`CLBE_CTRL_SOM])
                    ctrl_r[`CLBE_CTRL_SOM] <= 1'b1;
                if (pwdata[`CLBE_CTRL_EOM])
                    ctrl_r[`CLBE_CTRL_EOM] <= 1'b1;
            end
            // hardware clears start/end
            // Arbitration loss leaves them pending so the engine retries
            if (txAbort || evt.txLastDone)
            begin
                ctrl_r[`CLBE_CTRL_SOM] <= 1'b0;
                ctrl_r[`CLBE_CTRL_EOM] <= 1'b0;
            end
        end
    end

    // Configuration is plain storage
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cfg_r <= `CLBE_RESET_WORD;
        else if (wrEn && isReg(paddr, `CLBE_OFS_CFG))
        begin
            for (int i = 0; i < 4; i++)
                if (pstrb[i])
                    cfg_r[i*8 +: 8] <= pwdata[i*8 +: 8];
        end
    end

    // transmit byte store, consumed when the engine takes it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txByte_r <= 8'h00;
            txValid_r <= 1'b0;
        end
        else if (!ctrl_r[`CLBE_CTRL_EN])
            txValid_r <= 1'b0;
        else if (wrEn && isReg(paddr, `CLBE_OFS_TXBYTE) && pstrb[0])
        begin
            txByte_r <= pwdata[7:0];
            txValid_r <= 1'b1;
        end
        else if (evt.txByteNeed || txAbort)
            txValid_r <= 1'b0;
    end

    // receive byte updated on every store
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rxByte_r <= 8'h00;
        else if (evt.rxByteStore)
            rxByte_r <= rxByte;
    end

    // Flag set terms; disabled peripheral raises nothing
    always_comb
    begin
        flags_nxt = '0;
        if (ctrl_r[`CLBE_CTRL_EN])
        begin
            flags_nxt[`CLBE_RX_BYTE_READY_FLAG] = evt.rxByteStore;
            flags_nxt[`CLBE_RX_DONE_FLAG] = evt.rxByteStore && evt.rxLast;
            flags_nxt[`CLBE_RX_OVERRUN_FLAG] = overrun;
            flags_nxt[`CLBE_BRE] = evt.risingErr;
            flags_nxt[`CLBE_SHORT_PERIOD_ERROR_FLAG] = evt.shortPeriod;
            flags_nxt[`CLBE_LONG_PERIOD_ERROR_FLAG] = evt.longPeriod;
            flags_nxt[`CLBE_RXACK] = evt.rxAckMiss
                && (bcast || evt.rxForeign);
            flags_nxt[`CLBE_ARBL] = evt.arbLost;
            flags_nxt[`CLBE_TX_BYTE_REQUEST_FLAG] = evt.txFourthBit;
            flags_nxt[`CLBE_TX_DONE_FLAG] = evt.txLastDone && !txAbort;
            flags_nxt[`CLBE_TX_UNDERRUN_FLAG] = evt.txByteNeed && !txValid_r;
            flags_nxt[`CLBE_TX_LINE_ERROR_FLAG] = evt.txLineErr;
            flags_nxt[`CLBE_TXACK] = evt.txAckMiss;
        end
    end

    // sticky flags, write one clears, a new event wins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            flags_r <= '0;
        else if (wrEn && isReg(paddr, `CLBE_OFS_STATUS))
            flags_r <= (flags_r & ~clbe_flags_t'(pwdata[12:0]))
                | flags_nxt;
        else
            flags_r <= flags_r | flags_nxt;
    end

    // Enables; writing while enabled is software's hazard, still stored
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ien_r <= '0;
        else if (wrEn && isReg(paddr, `CLBE_OFS_ENABLE))
            ien_r <= pwdata[12:0];
    end

    assign irq = |(flags_r & ien_r);

    // Link activity tracking
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state_r <= CLBE_IDLE;
        else
        begin
            case (state_r)
                CLBE_IDLE:
                    if (ctrl_r[`CLBE_CTRL_EN] && ctrl_r[`CLBE_CTRL_SOM])
                        state_r <= CLBE_SEND;
                    else if (evt.rxByteStore)
                        state_r <= CLBE_RECV;
                CLBE_SEND:
                    if (!ctrl_r[`CLBE_CTRL_EN] || txAbort || evt.txLastDone)
                        state_r <= CLBE_IDLE;
                    else if (evt.arbLost)
                        state_r <= CLBE_RECV;
                CLBE_RECV:
                    if (!ctrl_r[`CLBE_CTRL_EN] || rxStop
                        || (evt.rxByteStore && evt.rxLast))
                        state_r <= CLBE_IDLE;
                default:
                    state_r <= CLBE_IDLE;
            endcase
        end
    end

    // Registered control toward the bit engine; abort and stop stay high while disabled
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ctl_r <= '0;
        else
        begin
            ctl_r.abortTx <= txAbort || !ctrl_r[`CLBE_CTRL_EN];
            ctl_r.stopRx <= rxStop || !ctrl_r[`CLBE_CTRL_EN];
            ctl_r.errorBit <= ctrl_r[`CLBE_CTRL_EN] && (evt.shortPeriod
                || (evt.longPeriod
                    && (cfg_r[`CLBE_CFG_LONG_PERIOD_ERRBIT_EN] || bcast))
                || (evt.risingErr && cfg_r[`CLBE_CFG_RISING_ERROR_ERRBIT_EN]));
            ctl_r.nack <= overrun && bcast;
        end
    end

    always_comb
    begin
        ctl = ctl_r;
        ctl.enable = ctrl_r[`CLBE_CTRL_EN];
        ctl.startMsg = ctrl_r[`CLBE_CTRL_SOM];
        ctl.endMsg = ctrl_r[`CLBE_CTRL_EOM];
        ctl.listen = cfg_r[`CLBE_CFG_LISTEN];
    end

    assign txByte = txByte_r;
    assign txByteValid = txValid_r;
    assign linkState = state_r;

    // APB read mux, registered on the setup cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
        begin
            if (isReg(paddr, `CLBE_OFS_CTRL))
                prdata <= {29'h0, ctrl_r};
            else if (isReg(paddr, `CLBE_OFS_CFG))
                prdata <= cfg_r;
            else if (isReg(paddr, `CLBE_OFS_RXBYTE))
                prdata <= {24'h0, rxByte_r};
            else if (isReg(paddr, `CLBE_OFS_STATUS))
                prdata <= {19'h0, flags_r};
            else if (isReg(paddr, `CLBE_OFS_ENABLE))
                prdata <= {19'h0, ien_r};
            else
                prdata <= 32'h0;
        end
    end

    // Assertions
    sticky_flag_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            flags_r[`CLBE_RX_BYTE_READY_FLAG] && !(wrEn
            && isReg(paddr, `CLBE_OFS_STATUS) && pwdata[`CLBE_RX_BYTE_READY_FLAG])
            |=> flags_r[`CLBE_RX_BYTE_READY_FLAG])
        else $error("byte ready flag dropped without clear");
    byte_ready_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            ctrl_r[0] && evt.rxByteStore |=> flags_r[`CLBE_RX_BYTE_READY_FLAG]
            && rxByte_r == $past(rxByte))
        else $error("stored byte not flagged");
    rx_end_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            $rose(flags_r[`CLBE_RX_DONE_FLAG]) |-> $past(evt.rxByteStore))
        else $error("end flag without byte store");
    tx_abort_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            ctrl_r[0] && evt.txAckMiss |=> !ctrl_r[1] && !ctrl_r[2]
            && flags_r[`CLBE_TXACK])
        else $error("missing ack did not abort");
    arb_keep_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            ctrl_r[1] && evt.arbLost && !txAbort && !evt.txLastDone
            && ctrl_r[0] |=> ctrl_r[1])
        else $error("start request lost on arbitration");
    underrun_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            ctrl_r[0] && evt.txByteNeed && !txValid_r
            |=> flags_r[`CLBE_TX_UNDERRUN_FLAG] && !ctrl_r[1])
        else $error("underrun not raised");
    irq_gate_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            irq == |(flags_r & ien_r))
        else $error("interrupt not gated by enables");
    short_err_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            ctrl_r[0] && evt.shortPeriod |=> ctl.errorBit)
        else $error("short period without error bit");
    disable_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            !ctrl_r[0] |-> !ctrl_r[1] && !ctrl_r[2])
        else $error("controls set while disabled");
    overrun_a:
        assert property (@(posedge clk) disable iff (!rst_b)
            ctrl_r[0] && overrun |=> flags_r[`CLBE_RX_OVERRUN_FLAG] && ctl.stopRx)
        else $error("overrun not handled");
endmodule

// [dv/clbe_engine_model.sv]
// Bit engine stand-in that fires one event word per bench request
module clbe_engine_model
    import clbe_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request from the bench
    input wire logic fire,
    input wire clbe_evt_t fireEvt,
    input wire logic [7:0] fireByte,
    // Toward the core
    output clbe_evt_t evt,
    output logic [7:0] rxByte
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            evt <= '0;
            rxByte <= 8'h00;
        end
        else
        begin
            evt <= fire ? fireEvt : '0;
            // Byte lines are not held after a store, so show the inverse
            rxByte <= (fire && fireEvt.rxByteStore) ? fireByte : ~rxByte;
        end
    end
endmodule

// [dv/testbench.sv]
// Register-level bench of the link byte and event block
`include "clbe_defines.svh"
module testbench
    import clbe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, fire;
    logic txByteValid, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] fireByte, rxByte, txByte;
    clbe_evt_t evt, fireEvt;
    clbe_ctl_t ctl, ctlSeen;
    clbe_state_t linkState;
    int errors, check_count;

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    clbe_core dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
        .rxByte(rxByte), .ctl(ctl), .txByte(txByte),
        .txByteValid(txByteValid), .linkState(linkState), .irq(irq));

    clbe_engine_model engine (.clk(clk), .rst_b(rst_b), .fire(fire),
        .fireEvt(fireEvt), .fireByte(fireByte), .evt(evt), .rxByte(rxByte));

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdchk(input string what, input logic [11:0] a,
        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // Event word is taken by the core two edges after the request
    task automatic pulse(input logic [13:0] e, input logic [7:0] b);
        @(posedge clk);
        fire <= 1'b1;
        fireEvt <= clbe_evt_t'(e);
        fireByte <= b;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        #1 ctlSeen = ctl;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #20000;
        errors++;
        report_and_stop;
    end

    initial
    begin
        rst_b = 1'b0;
        {psel, penable, pwrite, fire} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        fireEvt = '0;
        fireByte = 8'h00;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rdchk("status", `CLBE_OFS_STATUS, 32'h0);
        rdchk("enable", `CLBE_OFS_ENABLE, 32'h0);
        rdchk("rxbyte", `CLBE_OFS_RXBYTE, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        // Enables go in while the link is still off
        apb(1'b1, `CLBE_OFS_ENABLE, 32'hffffffff);
        rdchk("enable", `CLBE_OFS_ENABLE, 32'h1fff);
        apb(1'b1, `CLBE_OFS_CTRL, 32'h1);
        apb(1'b1, `CLBE_OFS_CTRL, 32'h7);
        apb(1'b1, `CLBE_OFS_TXBYTE, 32'h1a5);
        #1 chk("txByte", 32'ha5, 32'(txByte));
        chk("txByteValid", 32'h1, 32'(txByteValid));
        pulse(14'h0800, 8'h00);
        chk("txByteValid", 32'h0, 32'(txByteValid));
        rdchk("status", `CLBE_OFS_STATUS, 32'h0);
        // Broadcast flavour on every event so receive errors apply
        for (int k = 4; k < 14; k++)
        begin
            apb(1'b1, `CLBE_OFS_CTRL, 32'h7);
            pulse((14'h1 << k) | 14'h2, 8'h00);
            chk("startMsg", 32'(k < 10), 32'(ctlSeen.startMsg));
            chk("endMsg", 32'(k < 10), 32'(ctlSeen.endMsg));
            if (k >= 11)
                chk("abortTx", 32'h1, 32'(ctlSeen.abortTx));
            if (k == 5 || k == 6)
                chk("errorBit", 32'h1, 32'(ctlSeen.errorBit));
            if (k == 4)
                chk("errorBit", 32'h0, 32'(ctlSeen.errorBit));
            if (k == 6 || k == 7)
                chk("stopRx", 32'h1, 32'(ctlSeen.stopRx));
            chk("irq", 32'h1, 32'(irq));
            rdchk("status", `CLBE_OFS_STATUS, 32'h1 << (k - 1));
            apb(1'b1, `CLBE_OFS_STATUS, 32'h1fff);
            #1 chk("irq", 32'h0, 32'(irq));
        end
        apb(1'b1, `CLBE_OFS_CTRL, 32'h1);
        pulse(14'h0008, 8'h3c);
        rdchk("status", `CLBE_OFS_STATUS, 32'h1);
        rdchk("rxbyte", `CLBE_OFS_RXBYTE, 32'h3c);
        // Broadcast flavour so the overrun must also answer negative
        pulse(14'h000a, 8'h5a);
        chk("stopRx", 32'h1, 32'(ctlSeen.stopRx));
        chk("nack", 32'h1, 32'(ctlSeen.nack));
        rdchk("status", `CLBE_OFS_STATUS, 32'h5);
        apb(1'b1, `CLBE_OFS_STATUS, 32'h1);
        rdchk("status", `CLBE_OFS_STATUS, 32'h4);
        apb(1'b1, `CLBE_OFS_STATUS, 32'h4);
        pulse(14'h000c, 8'hc3);
        rdchk("status", `CLBE_OFS_STATUS, 32'h3);
        rdchk("rxbyte", `CLBE_OFS_RXBYTE, 32'hc3);
        apb(1'b1, `CLBE_OFS_CTRL, 32'h7);
        apb(1'b1, `CLBE_OFS_CTRL, 32'h0);
        #1 chk("ctl en start end", 32'h0,
            32'({ctl.enable, ctl.startMsg, ctl.endMsg}));
        apb(1'b1, `CLBE_OFS_ENABLE, 32'h4);
        #1 chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, `CLBE_OFS_ENABLE, 32'h2);
        #1 chk("irq unmasked", 32'h1, 32'(irq));
        apb(1'b1, `CLBE_OFS_CFG, 32'h8000_0000);
        #1 chk("listen", 32'h1, 32'(ctl.listen));
        chk("linkState idle", 32'h1, 32'(linkState));
        pulse(14'h2000, 8'h00);
        rdchk("status", `CLBE_OFS_STATUS, 32'h3);
        report_and_stop;
    end
endmodule
